// [hdl/ssv_top.sv]
`include "ssv_cfg.svh"
`default_nettype none

// Function
// - internal reset follows power-on comparator
// - power-on reset clears reset-cause flags
// - watchdog/detector resets set own flag only
// - detector reset sets cause bit 0
// - ten level codes, others prohibited
// - detector keeps working in stop mode
// - control/status byte: enable, mode, flag
// - control/status survives detector reset only
// - level register survives detector reset only
// - enable starts comparator; 0.2 ms settle
// - mode 0 interrupt, mode 1 reset
// - flag shows below-level while enabled
// - flag bit is read-only
// - irq follows flag in interrupt mode
// - level register byte-wide, upper bits zero
// - reset mode holds reset while below
// - external reset or read clears causes
// - any reset sets detector irq mask
module ssv_top
  import ssv_pkg::*;
#(
  parameter int SETTLE_CYCLES = `SSV_SETTLE_CYC
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic power_below,
  input wire logic drop_below,
  input wire logic watchdog_reset_req,
  input wire logic stop_mode,
  input wire ssv_addr_t cpu_addr,
  input wire logic cpu_wr,
  input wire logic cpu_rd,
  input wire ssv_byte_t cpu_wdata,
  output ssv_byte_t cpu_rdata_r,
  output logic internal_reset_r,
  output logic detector_irq_r,
  output logic detector_irq_mask_r,
  output logic detector_enable_r,
  output logic [3:0] detector_level_code_r,
  output logic detector_level_ok_r,
  output logic detector_settled_r
);

  localparam ssv_count_t SETTLE_LAST = ssv_count_t'(SETTLE_CYCLES - 1);

  ssv_state_s st_r;
  ssv_state_s st_nxt;

  logic power_below_q;
  logic drop_below_q;

  // both analog outputs cross into clk_sys before any use
  ssv_sync3 #(
    .RESET_VAL(1'b1)
  ) u_power_sync (
    .clk_sys(clk_sys),
    .reset(reset),
    .async_in(power_below),
    .sync_out(power_below_q)
  );

  ssv_sync3 #(
    .RESET_VAL(1'b0)
  ) u_drop_sync (
    .clk_sys(clk_sys),
    .reset(reset),
    .async_in(drop_below),
    .sync_out(drop_below_q)
  );

  logic cpu_ok;
  logic wr_ctrl;
  logic wr_level;
  logic wr_mask;
  logic rd_cause;
  logic drop_rst_now;
  logic below_now;

  // cpu is held in reset while internal reset stands
  assign cpu_ok = !st_r.int_reset;
  assign wr_ctrl = cpu_ok && cpu_wr && (cpu_addr == `SSV_ADDR_CTRL);
  assign wr_level = cpu_ok && cpu_wr && (cpu_addr == `SSV_ADDR_LEVEL);
  assign wr_mask = cpu_ok && cpu_wr && (cpu_addr == `SSV_ADDR_MASK);
  assign rd_cause = cpu_ok && cpu_rd && (cpu_addr == `SSV_ADDR_CAUSE);
  // stop mode does not gate the detector path at all
  assign below_now = st_r.enable && drop_below_q;
  assign drop_rst_now = below_now && st_r.mode;

  always_comb begin
    st_nxt = st_r;

    st_nxt.flag = below_now;
    st_nxt.irq = below_now && !st_r.mode;
    st_nxt.drop_reset = drop_rst_now;
    st_nxt.int_reset = power_below_q || drop_rst_now || watchdog_reset_req;

    // register writes; the flag bit position is ignored
    if (wr_ctrl) begin
      st_nxt.enable = cpu_wdata[`SSV_CTRL_EN_BIT];
      st_nxt.mode = cpu_wdata[`SSV_CTRL_MODE_BIT];
    end
    // prohibited codes are stored as written; the analog side decides
    if (wr_level) begin
      st_nxt.level = cpu_wdata[`SSV_LEVEL_MSB:`SSV_LEVEL_LSB];
      st_nxt.level_ok = (cpu_wdata[`SSV_LEVEL_MSB:`SSV_LEVEL_LSB] <= `SSV_LEVEL_MAX);
    end
    if (wr_mask) begin
      st_nxt.mask = cpu_wdata[`SSV_MASK_BIT];
    end

    // settle timer: software should not trust the flag before it expires
    if (!st_r.enable) begin
      st_nxt.settle_cnt = '0;
      st_nxt.settled = 1'b0;
    end else if (st_r.settle_cnt != SETTLE_LAST) begin
      st_nxt.settle_cnt = st_r.settle_cnt + 16'h0001;
    end else begin
      st_nxt.settled = 1'b1;
    end

    // read data, with read-to-clear on the cause register
    st_nxt.rdata = 8'h00;
    if (cpu_ok && cpu_rd) begin
      case (cpu_addr)
        `SSV_ADDR_CTRL: begin
          st_nxt.rdata[`SSV_CTRL_EN_BIT] = st_r.enable;
          st_nxt.rdata[`SSV_CTRL_MODE_BIT] = st_r.mode;
          st_nxt.rdata[`SSV_CTRL_FLAG_BIT] = st_r.flag;
        end
        `SSV_ADDR_LEVEL: begin
          st_nxt.rdata[`SSV_LEVEL_MSB:`SSV_LEVEL_LSB] = st_r.level;
        end
        `SSV_ADDR_CAUSE: begin
          st_nxt.rdata[`SSV_CAUSE_DROP_BIT] = st_r.drop_cause;
          st_nxt.rdata[`SSV_CAUSE_WDT_BIT] = st_r.wdt_cause;
        end
        `SSV_ADDR_MASK: begin
          st_nxt.rdata[`SSV_MASK_BIT] = st_r.mask;
        end
        default: begin
          st_nxt.rdata = 8'h00;
        end
      endcase
    end
    if (rd_cause) begin
      st_nxt.drop_cause = 1'b0;
      st_nxt.wdt_cause = 1'b0;
    end

    // reset sources; a set here wins over the read-clear above
    if (power_below_q) begin
      st_nxt.enable = 1'b0;
      st_nxt.mode = 1'b0;
      st_nxt.flag = 1'b0;
      st_nxt.irq = 1'b0;
      st_nxt.level = 4'h0;
      st_nxt.level_ok = 1'b1;
      st_nxt.drop_cause = 1'b0;
      st_nxt.wdt_cause = 1'b0;
      st_nxt.mask = `SSV_MASK_RST;
      st_nxt.source = SSV_SRC_POWER;
    end else if (watchdog_reset_req) begin
      st_nxt.enable = 1'b0;
      st_nxt.mode = 1'b0;
      st_nxt.flag = 1'b0;
      st_nxt.irq = 1'b0;
      st_nxt.level = 4'h0;
      st_nxt.level_ok = 1'b1;
      st_nxt.wdt_cause = 1'b1;
      st_nxt.mask = `SSV_MASK_RST;
      st_nxt.source = SSV_SRC_WATCHDOG;
    end else if (drop_rst_now) begin
      // control and level held so the detector keeps watching
      st_nxt.drop_cause = 1'b1;
      st_nxt.mask = `SSV_MASK_RST;
      st_nxt.source = SSV_SRC_DROP;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      st_r.enable <= 1'b0;
      st_r.mode <= 1'b0;
      st_r.flag <= 1'b0;
      st_r.level <= 4'h0;
      st_r.level_ok <= 1'b1;
      st_r.drop_cause <= 1'b0;
      st_r.wdt_cause <= 1'b0;
      st_r.mask <= `SSV_MASK_RST;
      st_r.irq <= 1'b0;
      st_r.int_reset <= 1'b1;
      st_r.drop_reset <= 1'b0;
      st_r.rdata <= 8'h00;
      st_r.settle_cnt <= 16'h0000;
      st_r.settled <= 1'b0;
      st_r.source <= SSV_SRC_NONE;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign cpu_rdata_r = st_r.rdata;
  assign internal_reset_r = st_r.int_reset;
  assign detector_irq_r = st_r.irq;
  assign detector_irq_mask_r = st_r.mask;
  assign detector_enable_r = st_r.enable;
  assign detector_level_code_r = st_r.level;
  assign detector_level_ok_r = st_r.level_ok;
  assign detector_settled_r = st_r.settled;

  chk_power_reset: assert property (
    @(posedge clk_sys) disable iff (reset)
    power_below_q |=> internal_reset_r
  ) else $error("power-on comparator low but no internal reset");

  chk_power_release: assert property (
    @(posedge clk_sys) disable iff (reset)
    !power_below_q && !drop_rst_now && !watchdog_reset_req |=> !internal_reset_r
  ) else $error("internal reset not released");

  chk_power_clears: assert property (
    @(posedge clk_sys) disable iff (reset)
    power_below_q |=> !st_r.drop_cause && !st_r.wdt_cause && !detector_enable_r
  ) else $error("power-on reset left cause flags set");

  chk_wdt_cause: assert property (
    @(posedge clk_sys) disable iff (reset)
    watchdog_reset_req && !power_below_q
      |=> st_r.wdt_cause && !detector_enable_r && detector_level_code_r == 4'h0
  ) else $error("watchdog reset did not set its flag or clear control");

  chk_drop_cause: assert property (
    @(posedge clk_sys) disable iff (reset)
    drop_rst_now && !power_below_q && !watchdog_reset_req
      |=> st_r.drop_cause && internal_reset_r && detector_irq_mask_r
  ) else $error("detector reset did not set cause bit 0");

  chk_drop_holds: assert property (
    @(posedge clk_sys) disable iff (reset)
    drop_rst_now && !power_below_q && !watchdog_reset_req
      |=> detector_enable_r && st_r.mode && $stable(detector_level_code_r)
  ) else $error("detector reset disturbed control or level");

  chk_level_code: assert property (
    @(posedge clk_sys) disable iff (reset)
    wr_level && !power_below_q && !watchdog_reset_req
      |=> detector_level_ok_r == ($past(cpu_wdata[3:0]) <= 4'h9)
  ) else $error("level code validity wrong");

  chk_flag_off: assert property (
    @(posedge clk_sys) disable iff (reset)
    !detector_enable_r |=> !st_r.flag && !detector_irq_r
  ) else $error("flag set while detection disabled");

  chk_irq_follow: assert property (
    @(posedge clk_sys) disable iff (reset)
    detector_enable_r && !st_r.mode && drop_below_q && !power_below_q && !watchdog_reset_req
      |=> detector_irq_r && st_r.flag && !st_r.drop_reset
  ) else $error("irq does not follow flag in interrupt mode");

  chk_stop_runs: assert property (
    @(posedge clk_sys) disable iff (reset)
    stop_mode && drop_rst_now |=> internal_reset_r ##1 !cpu_ok || !drop_rst_now
  ) else $error("detector stalled in stop mode");

  chk_mask_reset: assert property (
    @(posedge clk_sys) disable iff (reset)
    internal_reset_r |-> detector_irq_mask_r
  ) else $error("irq mask not set during reset");

  chk_settle_wait: assert property (
    @(posedge clk_sys) disable iff (reset)
    $rose(detector_enable_r) |-> !detector_settled_r ##1 !detector_settled_r
  ) else $error("settled reported too early");

  chk_read_clear: assert property (
    @(posedge clk_sys) disable iff (reset)
    rd_cause && !watchdog_reset_req && !drop_rst_now
      |=> !st_r.drop_cause && !st_r.wdt_cause
  ) else $error("reading causes did not clear them");

  chk_ctrl_write: assert property (
    @(posedge clk_sys) disable iff (reset)
    wr_ctrl && !power_below_q && !watchdog_reset_req
      |=> detector_enable_r == $past(cpu_wdata[7]) && st_r.mode == $past(cpu_wdata[1])
  ) else $error("control write not stored");

  chk_level_write: assert property (
    @(posedge clk_sys) disable iff (reset)
    wr_level && !power_below_q && !watchdog_reset_req
      |=> detector_level_code_r == $past(cpu_wdata[3:0])
  ) else $error("level write not stored");

  chk_flag_track: assert property (
    @(posedge clk_sys) disable iff (reset)
    !power_below_q && !watchdog_reset_req |=> st_r.flag == $past(below_now)
  ) else $error("flag does not follow synced comparator");

  chk_mode_reset: assert property (
    @(posedge clk_sys) disable iff (reset)
    below_now && st_r.mode |=> internal_reset_r
  ) else $error("reset mode did not raise internal reset");

  chk_irq_mode: assert property (
    @(posedge clk_sys) disable iff (reset)
    st_r.mode |=> !detector_irq_r
  ) else $error("irq raised in reset mode");

  chk_wdt_keeps_drop: assert property (
    @(posedge clk_sys) disable iff (reset)
    watchdog_reset_req && !power_below_q && !rd_cause
      |=> st_r.drop_cause == $past(st_r.drop_cause)
  ) else $error("watchdog reset disturbed detector cause");

  chk_drop_keeps_wdt: assert property (
    @(posedge clk_sys) disable iff (reset)
    drop_rst_now && !power_below_q && !watchdog_reset_req && !rd_cause
      |=> st_r.wdt_cause == $past(st_r.wdt_cause)
  ) else $error("detector reset disturbed watchdog cause");

  chk_power_level: assert property (
    @(posedge clk_sys) disable iff (reset)
    power_below_q |=> detector_level_code_r == 4'h0 && !st_r.mode && detector_irq_mask_r
  ) else $error("power-on reset left level or mode");

  chk_read_level: assert property (
    @(posedge clk_sys) disable iff (reset)
    cpu_ok && cpu_rd && cpu_addr == `SSV_ADDR_LEVEL
      |=> cpu_rdata_r == {4'h0, $past(detector_level_code_r)}
  ) else $error("level read back wrong");

  chk_rdata_idle: assert property (
    @(posedge clk_sys) disable iff (reset)
    !cpu_rd |=> cpu_rdata_r == 8'h00
  ) else $error("read data not idle without read");

  chk_drop_source: assert property (
    @(posedge clk_sys) disable iff (reset)
    drop_rst_now && !power_below_q && !watchdog_reset_req
      |=> st_r.source == SSV_SRC_DROP
  ) else $error("detector reset source not recorded");

endmodule // ssv_top
`default_nettype wire

// [hdl/ssv_cfg.svh]
`ifndef SSV_CFG_SVH
`define SSV_CFG_SVH

// register map
`define SSV_ADDR_CTRL 16'hFF50
`define SSV_ADDR_LEVEL 16'hFF51
`define SSV_ADDR_CAUSE 16'hFF54
`define SSV_ADDR_MASK 16'hFF55

// control/status fields
`define SSV_CTRL_EN_BIT 7
`define SSV_CTRL_MODE_BIT 1
`define SSV_CTRL_FLAG_BIT 0
`define SSV_CTRL_RST 8'h00

// level select fields
`define SSV_LEVEL_LSB 0
`define SSV_LEVEL_MSB 3
`define SSV_LEVEL_MAX 4'h9
`define SSV_LEVEL_RST 8'h00

// reset-cause fields
`define SSV_CAUSE_DROP_BIT 0
`define SSV_CAUSE_WDT_BIT 4
`define SSV_CAUSE_RST 8'h00

// interrupt mask
`define SSV_MASK_BIT 0
`define SSV_MASK_RST 1'b1

// timing
`define SSV_CLK_NS 5
`define SSV_SETTLE_NS 200000
`define SSV_SETTLE_CYC ((`SSV_SETTLE_NS + `SSV_CLK_NS - 1) / `SSV_CLK_NS)

`endif

// [hdl/ssv_pkg.sv]
`default_nettype none
package ssv_pkg;

  typedef logic [7:0] ssv_byte_t;
  typedef logic [15:0] ssv_addr_t;
  typedef logic [15:0] ssv_count_t;

  typedef enum logic [1:0] {
    SSV_SRC_NONE,
    SSV_SRC_POWER,
    SSV_SRC_WATCHDOG,
    SSV_SRC_DROP
  } ssv_source_e;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic q;
  } ssv_sync_s;

  typedef struct packed {
    logic enable;
    logic mode;
    logic flag;
    logic [3:0] level;
    logic level_ok;
    logic drop_cause;
    logic wdt_cause;
    logic mask;
    logic irq;
    logic int_reset;
    logic drop_reset;
    ssv_byte_t rdata;
    ssv_count_t settle_cnt;
    logic settled;
    ssv_source_e source;
  } ssv_state_s;

endpackage
`default_nettype wire

// [hdl/ssv_sync3.sv]
`default_nettype none
module ssv_sync3
  import ssv_pkg::*;
#(
  parameter logic RESET_VAL = 1'b0
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic async_in,
  output logic sync_out
);

  ssv_sync_s st_r;
  ssv_sync_s st_nxt;

  // s1 feeds only s2; q moves once s2 and s3 agree
  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = async_in;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    if (st_r.s2 == st_r.s3) begin
      st_nxt.q = st_r.s3;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      st_r <= {RESET_VAL, RESET_VAL, RESET_VAL, RESET_VAL};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sync_out = st_r.q;

endmodule // ssv_sync3
`default_nettype wire

// [test/ssv_supply_model.sv]
`default_nettype none
module ssv_supply_model (
  input wire logic enable,
  input wire logic [3:0] level,
  input wire logic [15:0] supply_mv,
  output logic power_below,
  output logic drop_below
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] thr [10] = '{16'h10CC, 16'h1004, 16'h0F3C, 16'h0E74, 16'h0DAC,
    16'h0CE4, 16'h0C1C, 16'h0B22, 16'h0A28, 16'h092E};
  assign power_below = supply_mv < 16'h0834;
  // comparator off or bad code never trips
  assign drop_below = enable && level <= 4'h9 && supply_mv < thr[level];
endmodule // ssv_supply_model
`default_nettype wire

// [test/tb_top.sv]
`default_nettype none
module tb_top
  import ssv_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {ssv_addr_t a; ssv_byte_t d; ssv_byte_t e;} ssv_row_s;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic wd = 1'b0;
  logic stop = 1'b0;
  logic cpu_wr = 1'b0;
  logic cpu_rd = 1'b0;
  ssv_addr_t cpu_addr = '0;
  ssv_byte_t cpu_wdata = '0;
  ssv_byte_t rdata;
  logic [15:0] mv = 16'h1388;
  logic irst, irq, mask, en, lvl_ok, settled, pb, db;
  logic [3:0] lvl;
  int err_count = 0;
  int checks = 0;
  ssv_row_s rows [7] = '{
    '{16'hFF51, 8'h09, 8'h09}, '{16'hFF51, 8'h0A, 8'h0A}, '{16'hFF50, 8'h03, 8'h02},
    '{16'hFF50, 8'h01, 8'h00}, '{16'hFF55, 8'h00, 8'h00}, '{16'hFF52, 8'h5A, 8'h00},
    '{16'hFF51, 8'h00, 8'h00}};

  always #2.5 clk_sys = ~clk_sys;

  // short settle count keeps the run brief
  ssv_top #(.SETTLE_CYCLES(8)) ssv_top_inst (
    .clk_sys(clk_sys),
    .reset(reset),
    .power_below(pb),
    .drop_below(db),
    .watchdog_reset_req(wd),
    .stop_mode(stop),
    .cpu_addr(cpu_addr),
    .cpu_wr(cpu_wr),
    .cpu_rd(cpu_rd),
    .cpu_wdata(cpu_wdata),
    .cpu_rdata_r(rdata),
    .internal_reset_r(irst),
    .detector_irq_r(irq),
    .detector_irq_mask_r(mask),
    .detector_enable_r(en),
    .detector_level_code_r(lvl),
    .detector_level_ok_r(lvl_ok),
    .detector_settled_r(settled)
  );

  ssv_supply_model ssv_supply_model_inst (
    .enable(en),
    .level(lvl),
    .supply_mv(mv),
    .power_below(pb),
    .drop_below(db)
  );

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input ssv_addr_t a, input ssv_byte_t d);
    @(posedge clk_sys);
    cpu_addr <= a;
    cpu_wdata <= d;
    cpu_wr <= 1'b1;
    @(posedge clk_sys);
    cpu_wr <= 1'b0;
  endtask

  task automatic rd(input ssv_addr_t a, input ssv_byte_t e);
    @(posedge clk_sys);
    cpu_addr <= a;
    cpu_rd <= 1'b1;
    @(posedge clk_sys);
    cpu_rd <= 1'b0;
    #1 chk(rdata, e);
  endtask

  task automatic sup(input logic [15:0] v, input logic s);
    @(posedge clk_sys);
    mv <= v;
    stop <= s;
  endtask

  // bounded: comparator path is only a few flops deep
  task automatic wait_rst(input logic v);
    int n;
    n = 0;
    // look after the edge so the launching step is never sampled
    #1;
    while (irst !== v && n < 50) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    chk(irst, v);
  endtask

  task automatic wd_pulse();
    @(posedge clk_sys);
    wd <= 1'b1;
    @(posedge clk_sys);
    wd <= 1'b0;
    repeat (2) @(posedge clk_sys);
    wait_rst(1'b0);
  endtask

  task automatic complete_run();
    $display("checks=%0d err_count=%0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    repeat (5) @(posedge clk_sys);
    #1 chk(irst, 1'b1);
    @(posedge clk_sys);
    reset <= 1'b0;
    wait_rst(1'b0);
    chk(mask, 1'b1);
    rd(16'hFF50, 8'h00);
    rd(16'hFF51, 8'h00);
    rd(16'hFF54, 8'h00);
    rd(16'hFF55, 8'h01);
    for (int i = 0; i < 7; i++) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, rows[i].e);
    end
    wr(16'hFF51, 8'h0A);
    repeat (2) @(posedge clk_sys);
    #1 chk(lvl_ok, 1'b0);
    $display("done: registers");
    wr(16'hFF51, 8'h03);
    wr(16'hFF50, 8'h80);
    #1 chk(settled, 1'b0);
    repeat (12) @(posedge clk_sys);
    #1 chk(settled, 1'b1);
    sup(16'h0E10, 1'b1);
    repeat (8) @(posedge clk_sys);
    #1 chk(irq, 1'b1);
    rd(16'hFF50, 8'h81);
    wr(16'hFF50, 8'h00);
    repeat (2) @(posedge clk_sys);
    #1 chk(irq, 1'b0);
    rd(16'hFF50, 8'h00);
    $display("done: interrupt mode");
    sup(16'h1388, 1'b0);
    wr(16'hFF50, 8'h80);
    repeat (12) @(posedge clk_sys);
    wr(16'hFF50, 8'h82);
    sup(16'h0E10, 1'b1);
    wait_rst(1'b1);
    sup(16'h1388, 1'b0);
    wait_rst(1'b0);
    chk(mask, 1'b1);
    rd(16'hFF50, 8'h82);
    rd(16'hFF51, 8'h03);
    wd_pulse();
    rd(16'hFF54, 8'h11);
    rd(16'hFF54, 8'h00);
    rd(16'hFF50, 8'h00);
    rd(16'hFF51, 8'h00);
    $display("done: detector reset");
    wd_pulse();
    sup(16'h03E8, 1'b0);
    wait_rst(1'b1);
    sup(16'h1388, 1'b0);
    wait_rst(1'b0);
    rd(16'hFF54, 8'h00);
    wd_pulse();
    @(posedge clk_sys);
    reset <= 1'b1;
    repeat (6) @(posedge clk_sys);
    reset <= 1'b0;
    wait_rst(1'b0);
    rd(16'hFF54, 8'h00);
    $display("done: power and pin resets");
    complete_run();
  end

  initial begin
    #50000;
    err_count++;
    complete_run();
  end
endmodule // tb_top
`default_nettype wire
